// ---- common/bidir_fifo_regs.svh ----
// constants of the bidirectional two-queue buffer
`ifndef BIDIR_FIFO_REGS_SVH
`define BIDIR_FIFO_REGS_SVH
`define DATA_W       36
`define QUEUE_DEPTH  16384
`define PTR_W        14
`define CNT_W        15
`define BYTE_W       9
`define HALF_W       18
`define CNT_RST      15'h0000
`define LANE_RST     2'h0
`define LANE_LAST_LONG 2'h0
`define LANE_LAST_WORD 2'h1
`define LANE_LAST_BYTE 2'h3
`endif

// ---- common/bidir_fifo_pkg.sv ----
// types of the bidirectional two-queue buffer
`include "bidir_fifo_regs.svh"
package bidir_fifo_pkg;
	typedef enum logic [1:0] {WIDTH_LONG, WIDTH_WORD, WIDTH_BYTE} bus_width_type;

	// one queue with its read-side holding register
	typedef struct packed {
		logic [`PTR_W-1:0]  wr_ptr;
		logic [`PTR_W-1:0]  rd_ptr;
		logic [`CNT_W-1:0]  count;
		logic [`DATA_W-1:0] out_word;
		logic               out_valid;
	} queue_state_type;

	// two-stage flag pipeline of one port: empty/ready, full/ready, almost empty, almost full
	typedef struct packed {
		logic [3:0] stage1;
		logic [3:0] stage2;
	} flag_pipe_type;

	typedef struct packed {
		queue_state_type    ab;
		queue_state_type    ba;
		logic [1:0]         b_rd_lane;
		logic [1:0]         b_wr_lane;
		logic [`DATA_W-1:0] b_assembly;
		flag_pipe_type      a_flags;
		flag_pipe_type      b_flags;
		logic               in_reset;
		logic               big_endian;
	} fifo_state_type;
endpackage : bidir_fifo_pkg

// ---- hdl/bidir_fifo_flags_bus_config.sv ----
// two opposing queues with port B bus matching, endian select and almost flags
`timescale 1ns/1ps
`include "bidir_fifo_regs.svh"

// Overview of operation
// RULE1: port A almost-empty low when b-to-a word count at or below its offset.
// RULE2: port B almost-empty low when a-to-b word count at or below its offset.
// RULE3: port A almost-full low when a-to-b free locations at or below its offset.
// RULE4: port B almost-full low when b-to-a free locations at or below its offset.
// RULE5: port A is 36 bits, writes a-to-b and reads b-to-a.
// RULE6: port B is 36 bits, reads a-to-b and writes b-to-a.
// RULE7: select high at master reset gives big endian, high part first on B.
// RULE8: select low at master reset gives little endian, low part first on B.
// RULE9: after master reset the select picks standard (high) or fall-through (low) timing.
// RULE10: outside party holds the select static once timing is chosen.
// RULE11: width match high runs port B at byte or word width per size select.
// RULE12: width match low runs port B at full long-word width.
// RULE13: outside party holds width match static during operation.
// RULE14: port A clock runs continuously and times all port A transfers.
// RULE15: port A flags change only on rising clock edges.
// RULE16: works with port clocks asynchronous or coincident; here one clk serves both ports.
// RULE17: flags mean empty/full in standard mode, ready in fall-through mode.
// RULE18: port B supports 36, 18 and 9 bit transfers, ordered by endian.
// RULE19: all flags pass through two register stages before the pins.
// RULE20: endian captured at master reset release, kept through partial reset.
// RULE21: size select is one input, high chooses byte, low chooses word.
module bidir_fifo_flags_bus_config (
	input  wire logic                     clk,
	input  wire logic                     sys_rst,
	input  wire logic                     a_to_b_flush,
	input  wire logic                     b_to_a_flush,
	input  wire logic                     endian_timing_select,
	input  wire logic                     side_b_width_match,
	input  wire logic                     side_b_size_select,
	input  wire logic                     side_a_enable,
	input  wire logic                     side_a_write,
	input  wire logic [`DATA_W-1:0]       side_a_data_bus_in,
	output logic      [`DATA_W-1:0]       side_a_data_bus_out,
	output logic                          side_a_data_bus_oe,
	input  wire logic                     side_b_enable,
	input  wire logic                     side_b_write,
	input  wire logic [`DATA_W-1:0]       side_b_data_bus_in,
	output logic      [`DATA_W-1:0]       side_b_data_bus_out,
	output logic                          side_b_data_bus_oe,
	input  wire logic [`CNT_W-1:0]        a_almost_empty_offset,
	input  wire logic [`CNT_W-1:0]        b_almost_empty_offset,
	input  wire logic [`CNT_W-1:0]        a_almost_full_offset,
	input  wire logic [`CNT_W-1:0]        b_almost_full_offset,
	output logic                          side_a_empty_or_out_ready,
	output logic                          side_a_full_or_in_ready,
	output logic                          side_a_almost_empty_n,
	output logic                          side_a_almost_full_n,
	output logic                          side_b_empty_or_out_ready,
	output logic                          side_b_full_or_in_ready,
	output logic                          side_b_almost_empty_n,
	output logic                          side_b_almost_full_n,
	output logic                          fall_through_mode
);
	import bidir_fifo_pkg::*;

	fifo_state_type     state_ff;
	fifo_state_type     nxt_state;
	logic [`DATA_W-1:0] ab_mem [`QUEUE_DEPTH];
	logic [`DATA_W-1:0] ba_mem [`QUEUE_DEPTH];
	logic               ab_push;
	logic               ba_push;
	logic [`DATA_W-1:0] ba_push_word;
	bus_width_type      b_width;
	logic [1:0]         b_last_lane;

	////////////////////////////////////////////////////////////////////////////
	// lane helpers: lanes are numbered from the low end of the long word

	function automatic logic [`DATA_W-1:0] lane_get(input logic [`DATA_W-1:0] word,
			input bus_width_type width, input logic [1:0] idx);
		logic [`DATA_W-1:0] r;
		r = '0;
		case (width)
			WIDTH_BYTE: r[`BYTE_W-1:0] = word[idx*`BYTE_W +: `BYTE_W];
			WIDTH_WORD: r[`HALF_W-1:0] = word[idx[0]*`HALF_W +: `HALF_W];
			default:    r = word;
		endcase
		return r;
	endfunction : lane_get

	function automatic logic [`DATA_W-1:0] lane_put(input logic [`DATA_W-1:0] word,
			input logic [`DATA_W-1:0] data, input bus_width_type width, input logic [1:0] idx);
		logic [`DATA_W-1:0] r;
		r = word;
		case (width)
			WIDTH_BYTE: r[idx*`BYTE_W +: `BYTE_W] = data[`BYTE_W-1:0];
			WIDTH_WORD: r[idx[0]*`HALF_W +: `HALF_W] = data[`HALF_W-1:0];
			default:    r = data;
		endcase
		return r;
	endfunction : lane_put

	// physical lane of transfer k: big endian starts from the top lane
	function automatic logic [1:0] phys_lane(input logic big, input logic [1:0] last,
			input logic [1:0] k);
		return big ? 2'(last - k) : k;
	endfunction : phys_lane

	////////////////////////////////////////////////////////////////////////////
	// port B arrangement from the static width pins

	always_comb begin
		if (!side_b_width_match) begin
			b_width     = WIDTH_LONG; // [RULE12]
			b_last_lane = `LANE_LAST_LONG;
		end else if (side_b_size_select) begin
			b_width     = WIDTH_BYTE; // [RULE11] [RULE21]
			b_last_lane = `LANE_LAST_BYTE;
		end else begin
			b_width     = WIDTH_WORD; // [RULE11] [RULE21]
			b_last_lane = `LANE_LAST_WORD;
		end
	end

	assign fall_through_mode = ~state_ff.in_reset & ~endian_timing_select; // [RULE9]

	////////////////////////////////////////////////////////////////////////////
	// next-state logic for both queues, both ports and the flag pipes

	always_comb begin
		logic a_rd;
		logic a_wr;
		logic b_rd;
		logic b_wr;
		logic ab_pop;
		logic ba_pop;
		logic [1:0] lane;
		lane         = `LANE_RST;
		nxt_state    = state_ff;
		a_rd         = side_a_enable & ~side_a_write;
		a_wr         = side_a_enable & side_a_write;
		b_rd         = side_b_enable & ~side_b_write;
		b_wr         = side_b_enable & side_b_write;
		ab_pop       = 1'b0;
		ba_pop       = 1'b0;
		ab_push      = 1'b0;
		ba_push      = 1'b0;
		ba_push_word = '0;

		// endian is sampled on the first edge after master reset ends
		if (state_ff.in_reset) begin
			nxt_state.in_reset   = 1'b0;
			nxt_state.big_endian = endian_timing_select; // [RULE7] [RULE8] [RULE20]
		end

		// port A writes whole long words into a-to-b
		ab_push = a_wr && state_ff.ab.count != `CNT_W'(`QUEUE_DEPTH); // [RULE5] [RULE14]

		// port B writes lanes; the long word is stored after its last lane
		if (b_wr) begin
			lane = phys_lane(state_ff.big_endian, b_last_lane, state_ff.b_wr_lane);
			ba_push_word = lane_put(state_ff.b_assembly, side_b_data_bus_in, b_width, lane);
			if (state_ff.b_wr_lane != b_last_lane) begin
				nxt_state.b_assembly = ba_push_word; // [RULE18]
				nxt_state.b_wr_lane  = state_ff.b_wr_lane + 2'h1;
			end else if (state_ff.ba.count != `CNT_W'(`QUEUE_DEPTH)) begin
				ba_push              = 1'b1; // [RULE6]
				nxt_state.b_wr_lane  = `LANE_RST;
			end
		end

		// port A reads b-to-a; fall-through preloads the holding register
		if (fall_through_mode) begin
			if (a_rd && state_ff.ba.out_valid)
				nxt_state.ba.out_valid = 1'b0;
			if ((!state_ff.ba.out_valid || a_rd) && state_ff.ba.count != `CNT_RST)
				ba_pop = 1'b1;
		end else if (a_rd && state_ff.ba.count != `CNT_RST) begin
			ba_pop = 1'b1; // [RULE5]
		end

		// port B reads a-to-b lane by lane, popping a new word after the last lane
		if (fall_through_mode) begin
			if (b_rd && state_ff.ab.out_valid) begin
				if (state_ff.b_rd_lane != b_last_lane) begin
					nxt_state.b_rd_lane = state_ff.b_rd_lane + 2'h1; // [RULE18]
				end else begin
					nxt_state.ab.out_valid = 1'b0;
					nxt_state.b_rd_lane    = `LANE_RST;
				end
			end
			if (!nxt_state.ab.out_valid && state_ff.ab.count != `CNT_RST)
				ab_pop = 1'b1;
		end else if (b_rd) begin
			if (state_ff.ab.out_valid && state_ff.b_rd_lane != b_last_lane)
				nxt_state.b_rd_lane = state_ff.b_rd_lane + 2'h1; // [RULE18]
			else if (state_ff.ab.count != `CNT_RST)
				ab_pop = 1'b1; // [RULE6]
		end

		// pointer and count bookkeeping
		if (ab_pop) begin
			nxt_state.ab.out_word  = ab_mem[state_ff.ab.rd_ptr];
			nxt_state.ab.out_valid = 1'b1;
			nxt_state.ab.rd_ptr    = state_ff.ab.rd_ptr + `PTR_W'(1);
			nxt_state.b_rd_lane    = `LANE_RST;
		end
		if (ba_pop) begin
			nxt_state.ba.out_word  = ba_mem[state_ff.ba.rd_ptr];
			nxt_state.ba.out_valid = 1'b1;
			nxt_state.ba.rd_ptr    = state_ff.ba.rd_ptr + `PTR_W'(1);
		end
		if (ab_push)
			nxt_state.ab.wr_ptr = state_ff.ab.wr_ptr + `PTR_W'(1);
		if (ba_push)
			nxt_state.ba.wr_ptr = state_ff.ba.wr_ptr + `PTR_W'(1);
		nxt_state.ab.count = state_ff.ab.count + `CNT_W'(ab_push) - `CNT_W'(ab_pop);
		nxt_state.ba.count = state_ff.ba.count + `CNT_W'(ba_push) - `CNT_W'(ba_pop);

		// raw flags from the current counts, fall-through output-ready flags from the holding-register valid bits; one clock serves both ports [RULE16]
		nxt_state.a_flags.stage1 = {
			fall_through_mode ? state_ff.ba.out_valid
			                  : state_ff.ba.count != `CNT_RST, // [RULE17]
			state_ff.ab.count != `CNT_W'(`QUEUE_DEPTH), // [RULE17]
			state_ff.ba.count > a_almost_empty_offset, // [RULE1]
			(`CNT_W'(`QUEUE_DEPTH) - state_ff.ab.count) > a_almost_full_offset // [RULE3]
		};
		nxt_state.b_flags.stage1 = {
			fall_through_mode ? state_ff.ab.out_valid
			                  : state_ff.ab.count != `CNT_RST, // [RULE17]
			state_ff.ba.count != `CNT_W'(`QUEUE_DEPTH), // [RULE17]
			state_ff.ab.count > b_almost_empty_offset, // [RULE2]
			(`CNT_W'(`QUEUE_DEPTH) - state_ff.ba.count) > b_almost_full_offset // [RULE4]
		};
		nxt_state.a_flags.stage2 = state_ff.a_flags.stage1; // [RULE19]
		nxt_state.b_flags.stage2 = state_ff.b_flags.stage1; // [RULE19]

		// partial resets flush one queue and keep the configuration
		if (a_to_b_flush) begin
			nxt_state.ab        = '0;
			nxt_state.b_rd_lane = `LANE_RST;
		end
		if (b_to_a_flush) begin
			nxt_state.ba         = '0;
			nxt_state.b_wr_lane  = `LANE_RST;
			nxt_state.b_assembly = '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// state register; master reset clears data and configuration

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_ff          <= '0;
			state_ff.in_reset <= 1'b1;
		end else begin
			state_ff <= nxt_state; // [RULE15]
		end
	end

	// storage arrays, written without reset to stay a plain memory
	always_ff @(posedge clk) begin
		if (ab_push && !a_to_b_flush)
			ab_mem[state_ff.ab.wr_ptr] <= side_a_data_bus_in;
		if (ba_push && !b_to_a_flush)
			ba_mem[state_ff.ba.wr_ptr] <= ba_push_word;
	end

	////////////////////////////////////////////////////////////////////////////
	// pins: data drive only while the party reads, flags from the second stage

	assign side_a_data_bus_out = state_ff.ba.out_word;
	assign side_a_data_bus_oe  = side_a_enable & ~side_a_write;
	assign side_b_data_bus_out = lane_get(state_ff.ab.out_word, b_width,
		phys_lane(state_ff.big_endian, b_last_lane, state_ff.b_rd_lane)); // [RULE7] [RULE8]
	assign side_b_data_bus_oe  = side_b_enable & ~side_b_write;
	assign {side_a_empty_or_out_ready, side_a_full_or_in_ready,
		side_a_almost_empty_n, side_a_almost_full_n} = state_ff.a_flags.stage2;
	assign {side_b_empty_or_out_ready, side_b_full_or_in_ready,
		side_b_almost_empty_n, side_b_almost_full_n} = state_ff.b_flags.stage2;
endmodule : bidir_fifo_flags_bus_config

// ---- tb/bidir_fifo_monitor.sv ----
// pin-level assertions for the two-queue buffer
`timescale 1ns/1ps
module bidir_fifo_monitor (
	input wire logic	clk,
	input wire logic	sys_rst,
	input wire logic	a_to_b_flush,
	input wire logic	endian_timing_select,
	input wire logic	side_a_enable,
	input wire logic	side_a_write,
	input wire logic	side_b_enable,
	input wire logic	side_b_write,
	input wire logic	side_a_data_bus_oe,
	input wire logic	side_b_data_bus_oe,
	input wire logic	side_a_empty_or_out_ready,
	input wire logic	side_a_full_or_in_ready,
	input wire logic	side_a_almost_empty_n,
	input wire logic	side_a_almost_full_n,
	input wire logic	side_b_empty_or_out_ready,
	input wire logic	side_b_full_or_in_ready,
	input wire logic	side_b_almost_empty_n,
	input wire logic	side_b_almost_full_n,
	input wire logic	fall_through_mode
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// drivers turn on only for reads, so a write never fights the host
	chk_a_oe_read: assert property (side_a_data_bus_oe == (side_a_enable & ~side_a_write))
		else $error("port a drive enable wrong");
	chk_b_oe_read: assert property (side_b_data_bus_oe == (side_b_enable & ~side_b_write))
		else $error("port b drive enable wrong");
	// mode follows the select once the reset edge has passed
	chk_mode_follow: assert property (
		!$past(sys_rst) |-> fall_through_mode == !endian_timing_select)
		else $error("timing mode wrong");
	// an empty queue is always at or below any almost-empty offset
	chk_a_ae_empty: assert property (
		!side_a_empty_or_out_ready && !fall_through_mode |-> !side_a_almost_empty_n)
		else $error("port a almost empty high while empty");
	chk_b_ae_empty: assert property (
		!side_b_empty_or_out_ready && !fall_through_mode |-> !side_b_almost_empty_n)
		else $error("port b almost empty high while empty");
	// a full queue has zero free places, never above the offset
	chk_a_af_full: assert property (!side_a_full_or_in_ready |-> !side_a_almost_full_n)
		else $error("port a almost full high while full");
	chk_b_af_full: assert property (!side_b_full_or_in_ready |-> !side_b_almost_full_n)
		else $error("port b almost full high while full");
	// the far-side flag sees a new word after the two flag stages
	chk_ab_flag_lag: assert property (
		side_a_enable && side_a_write && !side_b_empty_or_out_ready && !fall_through_mode
		&& !a_to_b_flush && !$past(sys_rst) |-> ##[1:4] side_b_empty_or_out_ready)
		else $error("port b not-empty flag late");
endmodule : bidir_fifo_monitor
bind bidir_fifo_flags_bus_config bidir_fifo_monitor mon_u (.*);

// ---- tb/side_b_host.sv ----
// port b host model: moves one long word lane by lane
`timescale 1ns/1ps
module side_b_host (
	input  wire logic	clk,
	input  wire logic [35:0]	bus_out,
	output logic	en,
	output logic	wr,
	output logic [35:0]	bus_in
);
	initial begin
		en = 1'h0;
		wr = 1'h0;
		bus_in = 36'h0;
	end
	// fall-through shows a lane before its read, standard after it
	task automatic move(input int n, input bit big, ft, wr_en, inout logic [35:0] word);
		int i, k, w;
		logic [35:0] m;
		w = 36 / n;
		m = (36'h1 << w) - 36'h1;
		if (!wr_en) word = 36'h0;
		@(negedge clk);
		for (i = 0; i < n; i++) begin
			k = big ? n - 1 - i : i;
			if (ft && !wr_en) word = word | ((bus_out & m) << (k * w));
			en = 1'h1;
			wr = wr_en;
			bus_in = wr_en ? (word >> (k * w)) & m : ~bus_in;
			@(negedge clk);
			if (!ft && !wr_en) word = word | ((bus_out & m) << (k * w));
		end
		en = 1'h0;
		bus_in = ~bus_in; // released bus never keeps its last value
	endtask : move
endmodule : side_b_host

// ---- tb/tb.sv ----
// self-checking bench for the two-queue buffer
`timescale 1ns/1ps
module tb;
	logic clk, sys_rst, a_to_b_flush, b_to_a_flush, endian_timing_select;
	logic side_b_width_match, side_b_size_select, side_a_enable, side_a_write;
	logic side_b_enable, side_b_write, side_a_data_bus_oe, side_b_data_bus_oe;
	logic [35:0] side_a_data_bus_in, side_a_data_bus_out, side_b_data_bus_in, side_b_data_bus_out;
	logic [14:0] a_almost_empty_offset, b_almost_empty_offset, a_almost_full_offset, b_almost_full_offset;
	logic side_a_empty_or_out_ready, side_a_full_or_in_ready, side_a_almost_empty_n, side_a_almost_full_n;
	logic side_b_empty_or_out_ready, side_b_full_or_in_ready, side_b_almost_empty_n, side_b_almost_full_n;
	logic fall_through_mode;
	logic [3:0] cfg [4] = '{4'hF, 4'h6, 4'hB, 4'h0}; // reset select, run select, match, size
	int err_count, check_count, nl;
	bit big, ft;
	bidir_fifo_flags_bus_config dut_u (.*);
	side_b_host host_u (.clk(clk), .bus_out(side_b_data_bus_out), .en(side_b_enable),
		.wr(side_b_write), .bus_in(side_b_data_bus_in));
	// free-running clock
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	task automatic check(input string what, input logic [35:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic print_verdict();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	task automatic wait_ready(input bit on_b);
		int i;
		for (i = 0; i < 20 && (on_b ? side_b_empty_or_out_ready : side_a_empty_or_out_ready) !== 1'h1; i++)
			@(negedge clk);
		if (i == 20) begin
			err_count++;
			print_verdict();
		end
	endtask : wait_ready
	// select level at release fixes byte order; flush must not undo it
	task automatic cfg_reset(input bit rs, run, w, s);
		@(negedge clk);
		sys_rst = 1'h1;
		endian_timing_select = rs;
		side_b_width_match = w; // held for the whole run
		side_b_size_select = s;
		repeat (16) @(negedge clk);
		sys_rst = 1'h0;
		repeat (2) @(negedge clk);
		endian_timing_select = run; // held from here on
		{a_to_b_flush, b_to_a_flush} = 2'h3;
		@(negedge clk);
		{a_to_b_flush, b_to_a_flush} = 2'h0;
		repeat (4) @(negedge clk);
		big = rs;
		ft = !run;
		nl = w ? (s ? 4 : 2) : 1;
		check("mode", 36'(fall_through_mode), 36'(ft));
	endtask : cfg_reset
	task automatic a_write(input logic [35:0] d);
		@(negedge clk);
		side_a_enable = 1'h1;
		side_a_write = 1'h1;
		side_a_data_bus_in = d;
		@(negedge clk);
		side_a_enable = 1'h0;
		side_a_data_bus_in = ~d;
	endtask : a_write
	task automatic xfer_a_to_b(input logic [35:0] d);
		logic [35:0] got;
		a_write(d);
		wait_ready(1'h1);
		host_u.move(nl, big, ft, 1'h0, got);
		check("a_to_b word", got, d);
	endtask : xfer_a_to_b
	// fall-through shows the word with no read; standard needs one
	task automatic xfer_b_to_a(input logic [35:0] d);
		logic [35:0] w;
		w = d;
		host_u.move(nl, big, ft, 1'h1, w);
		wait_ready(1'h0);
		if (ft) check("b_to_a early word", side_a_data_bus_out, d);
		side_a_enable = 1'h1;
		side_a_write = 1'h0;
		@(negedge clk);
		side_a_enable = 1'h0;
		if (!ft) check("b_to_a word", side_a_data_bus_out, d);
	endtask : xfer_b_to_a
	// counts 0,1,2 against offsets 1 and 16383, both directions
	task automatic flag_levels();
		int k;
		logic [35:0] w;
		for (k = 0; k < 3; k++) begin
			repeat (6) @(negedge clk);
			check("a almost empty", 36'(side_a_almost_empty_n), 36'(k > 1));
			check("b almost empty", 36'(side_b_almost_empty_n), 36'(k > 1));
			check("a almost full", 36'(side_a_almost_full_n), 36'(k == 0));
			check("b almost full", 36'(side_b_almost_full_n), 36'(k == 0));
			check("a not empty", 36'(side_a_empty_or_out_ready), 36'(k > 0));
			check("b not empty", 36'(side_b_empty_or_out_ready), 36'(k > 0));
			check("a in ready", 36'(side_a_full_or_in_ready), 36'h1);
			check("b in ready", 36'(side_b_full_or_in_ready), 36'h1);
			w = 36'hA_5A5A_5A5A;
			a_write(w);
			host_u.move(nl, big, ft, 1'h1, w);
		end
	endtask : flag_levels
	initial begin
		{sys_rst, a_to_b_flush, b_to_a_flush, endian_timing_select} = 4'h8;
		{side_b_width_match, side_b_size_select, side_a_enable, side_a_write} = 4'h0;
		side_a_data_bus_in = 36'h0;
		{a_almost_empty_offset, b_almost_empty_offset} = {15'h0001, 15'h0001};
		{a_almost_full_offset, b_almost_full_offset} = {15'h3FFF, 15'h3FFF};
		foreach (cfg[i]) begin
			cfg_reset(cfg[i][3], cfg[i][2], cfg[i][1], cfg[i][0]);
			xfer_a_to_b(36'h1_2345_6789 + 36'(i));
			xfer_b_to_a(36'h9_8765_4321 - 36'(i));
		end
		cfg_reset(1'h1, 1'h1, 1'h1, 1'h1);
		flag_levels();
		print_verdict();
	end
endmodule : tb
